/* src/pwm_long_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the long PWM module
// Functional notes
// RQ1: Reload select steers compare addresses to reload
// RQ2: Software writes duty value right-justified
// RQ3: Output rises when low N bits match
// RQ4: Output falls on overflow out of bit N
// RQ5: Overflow sets flag, loads reload into compare
// RQ6: Software enables compare, pwm, length 9-11
// RQ7: Match sets event flag when enabled
// RQ8: Overflow recurs every 512/1024/2048 counts
// RQ9: Low byte write clears enable, high sets
// RQ10: Software writes low byte before high
// RQ11: High fraction is (2^N - value)/2^N
// RQ12: Compare disabled keeps output low
// RQ13: Flags stay set until software clears
`ifndef PWM_LONG_CFG_SVH
`define PWM_LONG_CFG_SVH
`define ADDR_CMP_LOW 4'h0
`define ADDR_CMP_HIGH 4'h1
`define ADDR_MODE_CFG 4'h2
`define ADDR_PWM_CFG 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_MASK 4'h5
`define ADDR_CTRL 4'h6
`define ADDR_COUNT_LOW 4'h7
`define ADDR_COUNT_HIGH 4'h8
`define MODE_MAT_BIT 3
`define MODE_PWM_BIT 1
`define MODE_ECOM_BIT 6
`define PWM_RELOAD_SELECT_BIT 7
`define PWM_CYCLE_LENGTH_SELECT_LSB 0
`define STAT_CYCLE_OVERFLOW_FLAG_BIT 0
`define STAT_CCF_BIT 1
`define CTRL_RUN_BIT 0
`define RESET_BYTE 8'h00
`define RESET_WORD 11'h000
`define CYCLES_9BIT 512
`define CYCLES_10BIT 1024
`define CYCLES_11BIT 2048
`endif

/* src/pwm_long_pkg.sv */
// Types shared by the long PWM module
package pwm_long_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
    typedef enum logic [1:0] {
        LEN_8 = 2'b00,
        LEN_9 = 2'b01,
        LEN_10 = 2'b10,
        LEN_11 = 2'b11
    } cycle_length_type;
endpackage

/* src/pwm_word_store.sv */
// Two-word store holding compare and auto-reload values with registered read
`timescale 1ns/1ns
module pwm_word_store #(
    parameter int WIDTH = 11
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_we,
    input wire logic i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_raddr,
    output logic [WIDTH-1:0] o_rdata,
    output logic [WIDTH-1:0] o_cmp,
    output logic [WIDTH-1:0] o_reload
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic [WIDTH-1:0] rdata_next;

    // Word 0 is the compare value, word 1 the auto-reload value
    always_comb begin
        mem_next[0] = mem_reg[0];
        mem_next[1] = mem_reg[1];
        if (i_we) begin
            mem_next[i_waddr] = i_wdata;
        end
        rdata_next = mem_reg[i_raddr];
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            o_rdata <= '0;
        end else begin
            mem_reg <= mem_next;
            o_rdata <= rdata_next;
        end
    end

    assign o_cmp = mem_reg[0];
    assign o_reload = mem_reg[1];
endmodule

/* src/pwm_long_module.sv */
// One counter array module in 9, 10 or 11-bit PWM mode with its register port
`timescale 1ns/1ns
`include "pwm_long_cfg.svh"
module pwm_long_module #(
    parameter int WIDTH = 11
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_module_output_pin,
    output logic o_irq
);
    import pwm_long_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    bus_req_type req;
    logic [7:0] mode_reg, mode_next;
    logic [7:0] pwm_cfg_reg, pwm_cfg_next;
    logic [1:0] status_reg, status_next;
    logic [1:0] mask_reg, mask_next;
    logic run_reg, run_next;
    logic [15:0] count_reg, count_next;
    logic out_reg, out_next;
    logic irq_next;
    logic [7:0] rdata_next;
    logic [3:0] raddr_reg;
    logic rd_d_reg;
    logic [7:0] rdata_mux;
    logic [WIDTH-1:0] cmp_val, reload_val, store_rdata;
    logic store_we, store_waddr;
    logic [WIDTH-1:0] store_wdata;
    logic [WIDTH-1:0] nmask;
    logic [WIDTH-1:0] cmp_now;
    logic match, overflow, reload_select;
    logic [15:0] count_inc;
    cycle_length_type cycle_length_select;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Mask of the low N counter bits for the chosen cycle length
    function automatic logic [WIDTH-1:0] len_mask(input cycle_length_type len);
        logic [WIDTH-1:0] m;
        m = '0;
        unique case (len)
            LEN_8: m = WIDTH'(11'h0FF);
            LEN_9: m = WIDTH'(11'h1FF);
            LEN_10: m = WIDTH'(11'h3FF);
            LEN_11: m = WIDTH'(11'h7FF);
        endcase
        return m;
    endfunction

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign cycle_length_select = cycle_length_type'(pwm_cfg_reg[`PWM_CYCLE_LENGTH_SELECT_LSB +: 2]);
    assign reload_select = pwm_cfg_reg[`PWM_RELOAD_SELECT_BIT];
    assign nmask = len_mask(cycle_length_select);
    assign count_inc = count_reg + 16'h0001;

    // Overflow out of bit N: the low N bits are all ones as the counter steps
    assign overflow = run_reg && ((count_reg[WIDTH-1:0] & nmask) == nmask); // [RQ4] [RQ8]
    // At overflow the reloaded value is the one that counts for the new cycle
    assign cmp_now = overflow ? reload_val : cmp_val; // [RQ5]
    // Look one count ahead so the pin is high while the count equals the compare;
    // a compare of all ones then still gives one high cycle instead of a stuck pin
    assign match = run_reg && mode_reg[`MODE_ECOM_BIT]
        && ((count_inc[WIDTH-1:0] & nmask) == (cmp_now & nmask)); // [RQ3] [RQ12] [RQ2]

    ////////////////////////////////////////////////////////////////////////////
    // Compare and reload store

    // Byte writes merge into the word selected by reload_select
    always_comb begin
        store_we = 1'b0;
        store_waddr = reload_select; // [RQ1]
        store_wdata = reload_select ? reload_val : cmp_val;
        if (req.wr && (req.addr == `ADDR_CMP_LOW)) begin
            store_we = 1'b1;
            store_wdata[7:0] = req.wdata;
        end else if (req.wr && (req.addr == `ADDR_CMP_HIGH)) begin
            store_we = 1'b1;
            store_wdata[WIDTH-1:8] = req.wdata[WIDTH-9:0];
        end
        // Overflow reload wins over a same-cycle software write to compare
        if (overflow) begin
            store_we = 1'b1;
            store_waddr = 1'b0;
            store_wdata = reload_val; // [RQ5]
        end
    end

    pwm_word_store #(
        .WIDTH(WIDTH)
    ) u_store (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_we(store_we),
        .i_waddr(store_waddr),
        .i_wdata(store_wdata),
        .i_raddr(reload_select),
        .o_rdata(store_rdata),
        .o_cmp(cmp_val),
        .o_reload(reload_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers and flags

    // Software writes, then hardware effects; set wins over write-one-clear
    always_comb begin
        mode_next = mode_reg;
        pwm_cfg_next = pwm_cfg_reg;
        mask_next = mask_reg;
        run_next = run_reg;
        status_next = status_reg;
        if (req.wr) begin
            unique case (req.addr)
                `ADDR_MODE_CFG: mode_next = req.wdata;
                `ADDR_PWM_CFG: pwm_cfg_next = req.wdata;
                `ADDR_MASK: mask_next = req.wdata[1:0];
                `ADDR_CTRL: run_next = req.wdata[`CTRL_RUN_BIT];
                `ADDR_STATUS: status_next = status_reg & ~req.wdata[1:0]; // [RQ13]
                `ADDR_CMP_LOW: mode_next[`MODE_ECOM_BIT] = 1'b0; // [RQ9]
                `ADDR_CMP_HIGH: mode_next[`MODE_ECOM_BIT] = 1'b1; // [RQ9] [RQ10]
                default: ;
            endcase
        end
        if (overflow) begin
            status_next[`STAT_CYCLE_OVERFLOW_FLAG_BIT] = 1'b1; // [RQ5] [RQ13]
        end
        if (match && mode_reg[`MODE_MAT_BIT]) begin
            status_next[`STAT_CCF_BIT] = 1'b1; // [RQ7] [RQ13]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            mode_reg <= `RESET_BYTE;
            pwm_cfg_reg <= `RESET_BYTE;
            mask_reg <= 2'h0;
            run_reg <= 1'b0;
            status_reg <= 2'h0;
        end else begin
            mode_reg <= mode_next;
            pwm_cfg_reg <= pwm_cfg_next;
            mask_reg <= mask_next;
            run_reg <= run_next;
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter and output pin

    // Rise on match, fall on overflow; high time is 2^N minus compare
    always_comb begin
        count_next = count_reg;
        out_next = out_reg;
        if (run_reg) begin
            count_next = count_inc;
        end
        if (req.wr && (req.addr == `ADDR_COUNT_LOW)) begin
            count_next[7:0] = req.wdata;
        end
        if (req.wr && (req.addr == `ADDR_COUNT_HIGH)) begin
            count_next[15:8] = req.wdata;
        end
        if (match) begin
            out_next = 1'b1; // [RQ3] [RQ11]
        end else if (overflow) begin
            out_next = 1'b0; // [RQ4]
        end
        if (!mode_reg[`MODE_ECOM_BIT] || !mode_reg[`MODE_PWM_BIT]) begin
            out_next = 1'b0; // [RQ12] [RQ6]
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            count_reg <= 16'h0000;
            out_reg <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            count_reg <= count_next;
            out_reg <= out_next;
            o_irq <= irq_next;
        end
    end

    assign o_module_output_pin = out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    // Store read data arrive a cycle late, so the byte is picked afterwards
    always_comb begin
        rdata_mux = 8'h00;
        unique case (raddr_reg)
            `ADDR_CMP_LOW: rdata_mux = store_rdata[7:0]; // [RQ1]
            `ADDR_CMP_HIGH: rdata_mux = {{(16 - WIDTH){1'b0}}, store_rdata[WIDTH-1:8]};
            `ADDR_MODE_CFG: rdata_mux = mode_reg;
            `ADDR_PWM_CFG: rdata_mux = pwm_cfg_reg;
            `ADDR_STATUS: rdata_mux = {6'h00, status_reg};
            `ADDR_MASK: rdata_mux = {6'h00, mask_reg};
            `ADDR_CTRL: rdata_mux = {7'h00, run_reg};
            `ADDR_COUNT_LOW: rdata_mux = count_reg[7:0];
            `ADDR_COUNT_HIGH: rdata_mux = count_reg[15:8];
            default: rdata_mux = 8'h00;
        endcase
        rdata_next = rd_d_reg ? rdata_mux : 8'h00;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            raddr_reg <= 4'h0;
            rd_d_reg <= 1'b0;
        end else begin
            raddr_reg <= req.addr;
            rd_d_reg <= req.rd;
        end
    end

    // Mux output drives the port directly: store and control state are registered
    assign o_rdata = rdata_next;
endmodule

/* tb/pwm_long_module_checker.sv */
// Port-level assertions for the long PWM module
`timescale 1ns/1ns
`include "pwm_long_cfg.svh"
module pwm_long_module_checker #(
    parameter int WIDTH = 11
) (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_module_output_pin,
    input wire logic o_irq
);
    logic ecom_reg, pwm_reg, mat_reg, wr_low, wr_high, gate, wclr, rd_mode;
    logic [1:0] mask_reg;
    // Decoded write and read events
    assign wr_low = i_wr && i_addr == `ADDR_CMP_LOW;
    assign wr_high = i_wr && i_addr == `ADDR_CMP_HIGH;
    assign wclr = i_wr && (i_addr == `ADDR_STATUS || i_addr == `ADDR_MASK);
    assign rd_mode = i_rd && i_addr == `ADDR_MODE_CFG;
    assign gate = ecom_reg && pwm_reg;
    // Enables rebuilt from writes alone, so they do not lean on the design's state
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            {ecom_reg, pwm_reg, mat_reg, mask_reg} <= '0;
        end else if (i_wr && i_addr == `ADDR_MODE_CFG) begin
            {ecom_reg, mat_reg, pwm_reg} <= {i_wdata[6], i_wdata[3], i_wdata[1]};
        end else if (i_wr && i_addr == `ADDR_MASK) begin
            mask_reg <= i_wdata[1:0];
        end else if (wr_low || wr_high) begin
            ecom_reg <= wr_high;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    chk_rise_gated: assert property ($rose(o_module_output_pin) |-> $past(gate))
        else $error("pin rose while disabled");
    chk_off_low: assert property (!gate && $past(!gate) |-> !o_module_output_pin)
        else $error("pin high while disabled");
    chk_low_clears: assert property (wr_low ##[1:2] rd_mode |=> !o_rdata[6])
        else $error("low write kept enable");
    chk_high_sets: assert property (wr_high ##[1:2] rd_mode |=> o_rdata[6])
        else $error("high write left enable clear");
    chk_match_flag: assert property ($rose(o_module_output_pin) && mat_reg && mask_reg[1]
        |-> ##[0:2] o_irq) else $error("match raised no flag");
    chk_ovf_flag: assert property ($fell(o_module_output_pin) && gate && mask_reg[0]
        |-> ##[0:2] o_irq) else $error("overflow raised no flag");
    chk_flag_sticky: assert property (o_irq && !wclr && !$past(wclr) |=> o_irq)
        else $error("flag dropped by itself");
    chk_irq_masked: assert property (mask_reg == 2'b00 && $past(mask_reg) == 2'b00
        && $past(mask_reg, 2) == 2'b00 |-> !o_irq) else $error("masked irq high");
    cover property ($rose(o_module_output_pin));
    cover property ($fell(o_module_output_pin));
    cover property ($rose(o_irq));
endmodule
bind pwm_long_module pwm_long_module_checker #(.WIDTH(WIDTH)) u_chk (.*);

/* tb/pwm_load_model.sv */
// Load on the PWM pin, timing high time and period between falling edges
`timescale 1ns/1ns
module pwm_load_model (
    input wire logic i_clk_sys,
    input wire logic i_pin,
    output int o_high = 0,
    output int o_period = 0
);
    int hc = 0;
    int pc = 0;
    logic prev = 1'b0;
    // A falling edge closes one cycle; both counts restart from it
    always @(posedge i_clk_sys) begin
        prev <= i_pin;
        if (prev && !i_pin) begin
            o_high <= hc;
            o_period <= pc;
            hc <= 0;
            pc <= 1;
        end else begin
            hc <= hc + int'(i_pin);
            pc <= pc + 1;
        end
    end
endmodule

/* tb/pwm_long_module_test.sv */
// Self-checking bench for the long PWM module
`timescale 1ns/1ns
`include "pwm_long_cfg.svh"
module pwm_long_module_test;
    import pwm_long_pkg::*;
    typedef struct {cycle_length_type len; logic [10:0] cmp; int high; int per;} row_type;
    row_type rows [3] = '{'{LEN_9, 11'h100, 256, 512}, '{LEN_10, 11'h001, 1023, 1024},
        '{LEN_11, 11'h7FF, 1, 2048}};
    logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, d;
    logic o_module_output_pin, o_irq;
    int o_high, o_period, fails = 0, n_tests = 0, k;
    pwm_long_module #(.WIDTH(11)) u_dut (.*);
    pwm_load_model u_load (.i_clk_sys(i_clk_sys), .i_pin(o_module_output_pin),
        .o_high(o_high), .o_period(o_period));
    // Free-running 100 MHz clock
    initial forever #5 i_clk_sys = ~i_clk_sys;
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bounded wait, so a stuck pin ends as a mismatch rather than a hang
    task automatic wait_pin(input logic v);
        for (k = 0; k < 5000 && o_module_output_pin !== v; k++) @(posedge i_clk_sys) #1;
        if (k == 5000) chk("pin wait", 1, 0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, one row each for the 9, 10 and 11-bit lengths, then the disabled and masked cases
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(`ADDR_STATUS);
        chk("status", 8'h00, d);
        chk("pin", 0, o_module_output_pin);
        foreach (rows[r]) begin
            wr(`ADDR_CTRL, 8'h00);
            wr(`ADDR_PWM_CFG, {6'h20, rows[r].len});
            wr(`ADDR_CMP_LOW, rows[r].cmp[7:0]);
            wr(`ADDR_CMP_HIGH, {5'h00, rows[r].cmp[10:8]});
            rd(`ADDR_CMP_HIGH);
            chk("reload", {5'h00, rows[r].cmp[10:8]}, d);
            wr(`ADDR_PWM_CFG, {6'h00, rows[r].len});
            wr(`ADDR_MODE_CFG, 8'h4A);
            wr(`ADDR_CMP_LOW, 8'h00);
            rd(`ADDR_MODE_CFG);
            chk("mode", 8'h0A, d);
            wr(`ADDR_CMP_HIGH, 8'h00);
            rd(`ADDR_MODE_CFG);
            chk("mode", 8'h4A, d);
            wr(`ADDR_MASK, 8'h03);
            wr(`ADDR_COUNT_LOW, 8'h00);
            wr(`ADDR_COUNT_HIGH, 8'h00);
            wr(`ADDR_CTRL, 8'h01);
            repeat (3) begin
                wait_pin(1);
                wait_pin(0);
            end
            @(posedge i_clk_sys) #1;
            chk("high", 16'(rows[r].high), 16'(o_high));
            chk("period", 16'(rows[r].per), 16'(o_period));
            rd(`ADDR_CMP_LOW);
            chk("loaded", rows[r].cmp[7:0], d);
            chk("irq", 1, o_irq);
            wr(`ADDR_CTRL, 8'h00);
            rd(`ADDR_STATUS);
            chk("status", 8'h03, d);
            wr(`ADDR_STATUS, 8'h03);
            rd(`ADDR_STATUS);
            chk("cleared", 8'h00, d);
        end
        wr(`ADDR_MASK, 8'h00);
        wr(`ADDR_CTRL, 8'h01);
        wr(`ADDR_CMP_LOW, 8'h10);
        k = 0;
        repeat (2100) @(posedge i_clk_sys) #1 k += o_module_output_pin;
        chk("zero duty", 0, 16'(k));
        chk("irq masked", 0, o_irq);
        rd(4'hF);
        chk("unmapped", 8'h00, d);
        tally_and_finish;
    end
    // Watchdog well beyond the expected run of some 16600 cycles
    initial begin
        #600000;
        fails++;
        tally_and_finish;
    end
endmodule
